// file: pkg/rps_pkg.sv
// package: register map, reset values and event carrier of the receive statistics block
package rps_pkg;

  // ------------------------------------------------------------
  // register word indices (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [6:0] IDX_OVERRUN = 7'h6b;
  localparam logic [6:0] IDX_SHORT_LO = 7'h6c;
  localparam logic [6:0] IDX_SHORT_HI = 7'h6d;
  localparam logic [6:0] IDX_LONG = 7'h6e;
  localparam logic [6:0] IDX_INT_STATUS = 7'h6f;
  localparam logic [6:0] IDX_INT_ENABLE = 7'h70;
  localparam logic [6:0] IDX_MIN_LEN = 7'h71;
  localparam logic [6:0] IDX_MAX_LEN = 7'h72;
  localparam logic [6:0] IDX_HDLC_CFG = 7'h73;

  // ------------------------------------------------------------
  // field positions and widths
  // ------------------------------------------------------------
  localparam int ADR_LSB = 2;
  localparam int SHORT_W = 27;
  localparam int SHORT_HI_W = 11;
  localparam int BIT_LONG_WRAP = 14;
  localparam int BIT_SHORT_WRAP = 13;
  localparam int BIT_BYTE_WRAP = 12;
  localparam int BIT_FRM_WRAP = 11;
  localparam int CFG_SHORT_DISCARD = 0;
  localparam int CFG_LONG_DISCARD = 1;
  localparam logic [15:0] INT_USED_MASK = 16'h7800;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_MIN_LEN = 16'h0004;
  localparam logic [15:0] RST_MAX_LEN = 16'h0600;
  localparam logic [15:0] RST_COUNT16 = 16'h0000;
  localparam logic [SHORT_W-1:0] RST_COUNT27 = 27'h0000000;
  localparam logic [15:0] RST_INT = 16'h0000;
  localparam logic [1:0] RST_CFG = 2'h0;

  // ------------------------------------------------------------
  // events from the receive frame processor, one-cycle pulses
  // ------------------------------------------------------------
  typedef struct packed {
    logic frame_done;
    logic frame_written;
    logic [15:0] payload_len;
    logic lost_partial;
    logic lost_whole;
    logic byte_count_wrap;
    logic good_frame_count_wrap;
  } rps_event_t;

endpackage

// file: hdl/rps_rx_stats.sv
// receive statistics counters with snapshot buffers and rollover interrupt flags
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
// What this block does
// R01 - 16-bit counter of frames lost to overrun
// R02 - count partly written and wholly dropped frames
// R03 - counter write copies to buffer and clears
// R04 - 27-bit counter of written frames below minimum
// R05 - short count ignores short discard enable
// R06 - short count split; upper write snapshots
// R07 - 16-bit counter of written frames above maximum
// R08 - long count ignores long discard enable
// R09 - status bit 14 on long counter wrap
// R10 - status bit 13 on short counter wrap
// R11 - status bit 12 on byte counter wrap
// R12 - status bit 11 on good frame wrap
// R13 - flags sticky until status read; bit 15 unused
// R14 - enable register gates each flag onto interrupt
// R15 - length counts bytes between control and checksum
// R16 - wrap means all ones to zero, continue
module rps_rx_stats (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [8:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // receive frame processor events
  input wire rps_pkg::rps_event_t evt_i,
  // configuration to the frame processor
  output logic short_frame_discard_enable_o,
  output logic long_frame_discard_enable_o,
  output logic [15:0] minimum_packet_length_o,
  output logic [15:0] maximum_packet_length_o,
  // interrupt
  output logic irq_o
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic [15:0] overrun_loss_count_ff, nxt_overrun_loss_count;
  logic [15:0] overrun_hold_ff, nxt_overrun_hold;
  logic [rps_pkg::SHORT_W-1:0] short_frame_count_ff, nxt_short_frame_count;
  logic [rps_pkg::SHORT_W-1:0] short_hold_ff, nxt_short_hold;
  logic [15:0] long_frame_count_ff, nxt_long_frame_count;
  logic [15:0] long_hold_ff, nxt_long_hold;
  logic [15:0] int_status_ff, nxt_int_status;
  logic [15:0] receive_interrupt_enable_ff, nxt_receive_interrupt_enable;
  logic [15:0] min_len_ff, nxt_min_len;
  logic [15:0] max_len_ff, nxt_max_len;
  logic [1:0] receive_hdlc_config_ff, nxt_receive_hdlc_config;
  logic irq_ff, nxt_irq;
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic access, wr, rd;
  logic [6:0] idx;
  logic snap_overrun, snap_short, snap_long;
  logic inc_overrun, inc_short, inc_long;
  logic wrap_short, wrap_long;
  logic [16:0] sum_overrun, sum_long;
  logic [rps_pkg::SHORT_W:0] sum_short;
  logic [15:0] set_bits;
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
    begin
      res[7:0] = data[7:0];
    end
    if (sel[1])
    begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction
  assign access = cyc_i && stb_i && !ack_ff;
  assign wr = access && we_i;
  assign rd = access && !we_i;
  assign idx = adr_i[8:rps_pkg::ADR_LSB];
  assign snap_overrun = wr && (idx == rps_pkg::IDX_OVERRUN);
  assign snap_short = wr && (idx == rps_pkg::IDX_SHORT_HI);
  assign snap_long = wr && (idx == rps_pkg::IDX_LONG);
  // ------------------------------------------------------------
  // frame qualification
  // ------------------------------------------------------------
  // payload_len is the information field only, between control and checksum [R15]
  assign inc_overrun = evt_i.lost_partial || evt_i.lost_whole; // [R01] [R02]
  // discard enables play no part in counting [R05] [R08]
  assign inc_short = evt_i.frame_done && evt_i.frame_written
                     && (evt_i.payload_len < min_len_ff); // [R04]
  assign inc_long = evt_i.frame_done && evt_i.frame_written
                    && (evt_i.payload_len > max_len_ff); // [R07]
  assign sum_overrun = {1'b0, overrun_loss_count_ff} + 17'h00001;
  assign sum_short = {1'b0, short_frame_count_ff} + 28'h0000001;
  assign sum_long = {1'b0, long_frame_count_ff} + 17'h00001;
  assign wrap_short = inc_short && sum_short[rps_pkg::SHORT_W]; // [R16]
  assign wrap_long = inc_long && sum_long[16]; // [R16]
  // ------------------------------------------------------------
  // counters and snapshot buffers
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_overrun_loss_count = overrun_loss_count_ff;
    nxt_overrun_hold = overrun_hold_ff;
    nxt_short_frame_count = short_frame_count_ff;
    nxt_short_hold = short_hold_ff;
    nxt_long_frame_count = long_frame_count_ff;
    nxt_long_hold = long_hold_ff;
    // a snapshot clears the counter but keeps an event of the same cycle
    if (snap_overrun)
    begin
      nxt_overrun_hold = overrun_loss_count_ff; // [R03]
      nxt_overrun_loss_count = inc_overrun ? 16'h0001 : rps_pkg::RST_COUNT16;
    end
    else if (inc_overrun)
    begin
      nxt_overrun_loss_count = sum_overrun[15:0]; // [R01]
    end
    if (snap_short)
    begin
      nxt_short_hold = short_frame_count_ff; // [R06]
      nxt_short_frame_count = inc_short ? 27'h0000001 : rps_pkg::RST_COUNT27;
    end
    else if (inc_short)
    begin
      nxt_short_frame_count = sum_short[rps_pkg::SHORT_W-1:0]; // [R04]
    end
    if (snap_long)
    begin
      nxt_long_hold = long_frame_count_ff; // [R03]
      nxt_long_frame_count = inc_long ? 16'h0001 : rps_pkg::RST_COUNT16;
    end
    else if (inc_long)
    begin
      nxt_long_frame_count = sum_long[15:0]; // [R07]
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      overrun_loss_count_ff <= rps_pkg::RST_COUNT16;
      overrun_hold_ff <= rps_pkg::RST_COUNT16;
      short_frame_count_ff <= rps_pkg::RST_COUNT27;
      short_hold_ff <= rps_pkg::RST_COUNT27;
      long_frame_count_ff <= rps_pkg::RST_COUNT16;
      long_hold_ff <= rps_pkg::RST_COUNT16;
    end
    else
    begin
      overrun_loss_count_ff <= nxt_overrun_loss_count;
      overrun_hold_ff <= nxt_overrun_hold;
      short_frame_count_ff <= nxt_short_frame_count;
      short_hold_ff <= nxt_short_hold;
      long_frame_count_ff <= nxt_long_frame_count;
      long_hold_ff <= nxt_long_hold;
    end
  end
  // ------------------------------------------------------------
  // interrupt flags, enables and configuration
  // ------------------------------------------------------------
  always_comb
  begin
    set_bits = 16'h0000;
    set_bits[rps_pkg::BIT_LONG_WRAP] = wrap_long; // [R09]
    set_bits[rps_pkg::BIT_SHORT_WRAP] = wrap_short; // [R10]
    set_bits[rps_pkg::BIT_BYTE_WRAP] = evt_i.byte_count_wrap; // [R11]
    set_bits[rps_pkg::BIT_FRM_WRAP] = evt_i.good_frame_count_wrap; // [R12]
    nxt_int_status = int_status_ff;
    // a read clears the flags, a set in the same cycle wins
    if (rd && (idx == rps_pkg::IDX_INT_STATUS))
    begin
      nxt_int_status = rps_pkg::RST_INT; // [R13]
    end
    nxt_int_status = nxt_int_status | set_bits; // [R13]
    nxt_receive_interrupt_enable = receive_interrupt_enable_ff;
    nxt_min_len = min_len_ff;
    nxt_max_len = max_len_ff;
    nxt_receive_hdlc_config = receive_hdlc_config_ff;
    if (wr && (idx == rps_pkg::IDX_INT_ENABLE))
    begin
      nxt_receive_interrupt_enable = merge16(receive_interrupt_enable_ff, dat_i, sel_i)
                                     & rps_pkg::INT_USED_MASK;
    end
    if (wr && (idx == rps_pkg::IDX_MIN_LEN))
    begin
      nxt_min_len = merge16(min_len_ff, dat_i, sel_i);
    end
    if (wr && (idx == rps_pkg::IDX_MAX_LEN))
    begin
      nxt_max_len = merge16(max_len_ff, dat_i, sel_i);
    end
    if (wr && (idx == rps_pkg::IDX_HDLC_CFG) && sel_i[0])
    begin
      nxt_receive_hdlc_config = dat_i[1:0];
    end
    nxt_irq = |(nxt_int_status & nxt_receive_interrupt_enable); // [R14]
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      int_status_ff <= rps_pkg::RST_INT;
      receive_interrupt_enable_ff <= rps_pkg::RST_INT;
      min_len_ff <= rps_pkg::RST_MIN_LEN;
      max_len_ff <= rps_pkg::RST_MAX_LEN;
      receive_hdlc_config_ff <= rps_pkg::RST_CFG;
      irq_ff <= 1'b0;
    end
    else
    begin
      int_status_ff <= nxt_int_status;
      receive_interrupt_enable_ff <= nxt_receive_interrupt_enable;
      min_len_ff <= nxt_min_len;
      max_len_ff <= nxt_max_len;
      receive_hdlc_config_ff <= nxt_receive_hdlc_config;
      irq_ff <= nxt_irq;
    end
  end
  // ------------------------------------------------------------
  // bus answer: ack one cycle after the request, data with it
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_ack = access;
    nxt_dat = 32'h00000000;
    if (rd)
    begin
      case (idx)
        rps_pkg::IDX_OVERRUN: nxt_dat[15:0] = overrun_hold_ff; // [R03]
        rps_pkg::IDX_SHORT_LO: nxt_dat[15:0] = short_hold_ff[15:0]; // [R06]
        rps_pkg::IDX_SHORT_HI: nxt_dat[rps_pkg::SHORT_HI_W-1:0] =
          short_hold_ff[rps_pkg::SHORT_W-1:16]; // [R06]
        rps_pkg::IDX_LONG: nxt_dat[15:0] = long_hold_ff; // [R03]
        rps_pkg::IDX_INT_STATUS: nxt_dat[15:0] = int_status_ff;
        rps_pkg::IDX_INT_ENABLE: nxt_dat[15:0] = receive_interrupt_enable_ff;
        rps_pkg::IDX_MIN_LEN: nxt_dat[15:0] = min_len_ff;
        rps_pkg::IDX_MAX_LEN: nxt_dat[15:0] = max_len_ff;
        rps_pkg::IDX_HDLC_CFG: nxt_dat[1:0] = receive_hdlc_config_ff;
        default: nxt_dat = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end
  assign ack_o = ack_ff;
  assign dat_o = dat_ff;
  assign irq_o = irq_ff;
  assign minimum_packet_length_o = min_len_ff;
  assign maximum_packet_length_o = max_len_ff;
  assign short_frame_discard_enable_o = receive_hdlc_config_ff[rps_pkg::CFG_SHORT_DISCARD];
  assign long_frame_discard_enable_o = receive_hdlc_config_ff[rps_pkg::CFG_LONG_DISCARD];
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_overrun_count;
    inc_overrun && !snap_overrun |=>
      overrun_loss_count_ff == $past(overrun_loss_count_ff) + 16'h0001;
  endproperty
  a_overrun_count: assert property (p_overrun_count) // [R01] [R02]
    else $error("overrun loss count did not step");
  property p_snapshot;
    snap_overrun |=> overrun_hold_ff == $past(overrun_loss_count_ff)
      && overrun_loss_count_ff == {15'h0000, $past(inc_overrun)};
  endproperty
  a_snapshot: assert property (p_snapshot) // [R03]
    else $error("overrun snapshot or clear wrong");
  property p_short_count;
    inc_short && !snap_short |=>
      short_frame_count_ff == $past(short_frame_count_ff) + 27'h0000001;
  endproperty
  a_short_count: assert property (p_short_count) // [R04] [R05]
    else $error("short frame count did not step");
  property p_short_wrap;
    inc_short && !snap_short && short_frame_count_ff == {rps_pkg::SHORT_W{1'b1}} |=>
      short_frame_count_ff == rps_pkg::RST_COUNT27 && int_status_ff[rps_pkg::BIT_SHORT_WRAP];
  endproperty
  a_short_wrap: assert property (p_short_wrap) // [R10] [R16]
    else $error("short counter wrap not flagged");
  property p_short_hi_read;
    rd && idx == rps_pkg::IDX_SHORT_HI |=>
      ack_o && dat_o == {21'h000000, short_hold_ff[rps_pkg::SHORT_W-1:16]};
  endproperty
  a_short_hi_read: assert property (p_short_hi_read) // [R06]
    else $error("short count upper read wrong");
  property p_long_count;
    inc_long && !snap_long && long_frame_count_ff != 16'hffff |=>
      long_frame_count_ff == $past(long_frame_count_ff) + 16'h0001;
  endproperty
  a_long_count: assert property (p_long_count) // [R07] [R08]
    else $error("long frame count did not step");
  property p_long_wrap;
    inc_long && !snap_long && long_frame_count_ff == 16'hffff |=>
      long_frame_count_ff == 16'h0000 && int_status_ff[rps_pkg::BIT_LONG_WRAP]
      && (irq_o || !receive_interrupt_enable_ff[rps_pkg::BIT_LONG_WRAP]);
  endproperty
  a_long_wrap: assert property (p_long_wrap) // [R09] [R16]
    else $error("long counter wrap not flagged");
  property p_byte_wrap;
    evt_i.byte_count_wrap |=> int_status_ff[rps_pkg::BIT_BYTE_WRAP];
  endproperty
  a_byte_wrap: assert property (p_byte_wrap) // [R11]
    else $error("byte wrap flag not set");
  property p_read_clear;
    rd && idx == rps_pkg::IDX_INT_STATUS && !evt_i.good_frame_count_wrap |=>
      !int_status_ff[rps_pkg::BIT_FRM_WRAP] && dat_o[15:0] == $past(int_status_ff);
  endproperty
  a_read_clear: assert property (p_read_clear) // [R12] [R13]
    else $error("status read did not clear");
  property p_irq;
    irq_o == |(int_status_ff & receive_interrupt_enable_ff);
  endproperty
  a_irq: assert property (p_irq) // [R14]
    else $error("interrupt output disagrees with flags");

endmodule

// file: verification/rps_rx_stats_tb.sv
// self-checking testbench of the receive statistics block
`timescale 1ns/10ps
module rps_rx_stats_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [8:0] adr_i = 9'h000;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic ack_o;
  rps_pkg::rps_event_t evt_i = '0;
  logic sde_o;
  logic lde_o;
  logic [15:0] min_o;
  logic [15:0] max_o;
  logic irq_o;
  int num_errors = 0;
  int n_tests = 0;
  logic [31:0] rd;

  rps_rx_stats u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .evt_i(evt_i), .short_frame_discard_enable_o(sde_o),
    .long_frame_discard_enable_o(lde_o), .minimum_packet_length_o(min_o),
    .maximum_packet_length_o(max_o), .irq_o(irq_o)
  );

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // report and compare
  // ------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // ------------------------------------------------------------
  // wishbone classic single cycle
  // ------------------------------------------------------------
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      num_errors++;
      final_report();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // holds an event for n edges, then one idle edge lets the count land
  task automatic pulse(input rps_pkg::rps_event_t v, input int n);
    evt_i <= v;
    repeat (n) @(posedge clk_i);
    evt_i <= '0;
    @(posedge clk_i);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk({16'h0000, min_o}, 32'h00000004);
    chk({16'h0000, max_o}, 32'h00000600);
    chk_bit(irq_o, 1'b0);
    rd_chk(9'h1c4, 32'h00000004);
    rd_chk(9'h1c8, 32'h00000600);
    rd_chk(9'h1c0, 32'h00000000);
    rd_chk(9'h1bc, 32'h00000000);
    rd_chk(9'h100, 32'h00000000);
    wb(1'b1, 9'h100, 32'h0000ffff);
    wb(1'b1, 9'h1bc, 32'h0000ffff);
    rd_chk(9'h1bc, 32'h00000000);
    $display("test reset done");
  endtask

  task automatic t_overrun();
    pulse('{lost_whole: 1'b1, default: '0}, 1);
    pulse('{lost_partial: 1'b1, default: '0}, 1);
    pulse('{lost_partial: 1'b1, lost_whole: 1'b1, default: '0}, 1);
    pulse('{lost_whole: 1'b1, default: '0}, 2);
    rd_chk(9'h1ac, 32'h00000000);
    wb(1'b1, 9'h1ac, 32'h0);
    rd_chk(9'h1ac, 32'h00000005);
    wb(1'b1, 9'h1ac, 32'h0);
    rd_chk(9'h1ac, 32'h00000000);
    $display("test overrun done");
  endtask

  task automatic t_short();
    wb(1'b1, 9'h1cc, 32'h00000001);
    chk_bit(sde_o, 1'b1);
    pulse('{frame_done: 1'b1, frame_written: 1'b1, payload_len: 16'h0003, default: '0}, 2);
    pulse('{frame_done: 1'b1, payload_len: 16'h0003, default: '0}, 1);
    pulse('{frame_done: 1'b1, frame_written: 1'b1, payload_len: 16'h0004, default: '0}, 1);
    pulse('{frame_done: 1'b1, frame_written: 1'b1, default: '0}, 1);
    wb(1'b1, 9'h1b0, 32'h0);
    rd_chk(9'h1b0, 32'h00000000);
    wb(1'b1, 9'h1b4, 32'h0);
    rd_chk(9'h1b0, 32'h00000003);
    rd_chk(9'h1b4, 32'h00000000);
    $display("test short done");
  endtask

  task automatic t_flags();
    pulse('{byte_count_wrap: 1'b1, good_frame_count_wrap: 1'b1, default: '0}, 1);
    chk_bit(irq_o, 1'b0);
    rd_chk(9'h1bc, 32'h00001800);
    rd_chk(9'h1bc, 32'h00000000);
    wb(1'b1, 9'h1c0, 32'h0000ffff);
    rd_chk(9'h1c0, 32'h00007800);
    wb(1'b1, 9'h1c0, 32'h00001000);
    pulse('{good_frame_count_wrap: 1'b1, default: '0}, 1);
    chk_bit(irq_o, 1'b0);
    pulse('{byte_count_wrap: 1'b1, default: '0}, 1);
    repeat (3) @(posedge clk_i);
    chk_bit(irq_o, 1'b1);
    rd_chk(9'h1bc, 32'h00001800);
    chk_bit(irq_o, 1'b0);
    $display("test flags done");
  endtask

  task automatic t_long();
    wb(1'b1, 9'h1cc, 32'h00000002);
    chk_bit(lde_o, 1'b1);
    wb(1'b1, 9'h1c0, 32'h00004000);
    pulse('{frame_done: 1'b1, frame_written: 1'b1, payload_len: 16'h0601, default: '0}, 65535);
    chk_bit(irq_o, 1'b0);
    pulse('{frame_done: 1'b1, frame_written: 1'b1, payload_len: 16'h0601, default: '0}, 3);
    pulse('{frame_done: 1'b1, frame_written: 1'b1, payload_len: 16'h0600, default: '0}, 1);
    chk_bit(irq_o, 1'b1);
    wb(1'b1, 9'h1b8, 32'h0);
    rd_chk(9'h1b8, 32'h00000002);
    rd_chk(9'h1bc, 32'h00004000);
    chk_bit(irq_o, 1'b0);
    $display("test long done");
  endtask

  // programmed limits move the short and long thresholds
  task automatic t_limits();
    wb(1'b1, 9'h1c4, 32'h00000010);
    wb(1'b1, 9'h1c8, 32'h00000020);
    chk({16'h0000, min_o}, 32'h00000010);
    chk({16'h0000, max_o}, 32'h00000020);
    rd_chk(9'h1c4, 32'h00000010);
    rd_chk(9'h1c8, 32'h00000020);
    pulse('{frame_done: 1'b1, frame_written: 1'b1, payload_len: 16'h000f, default: '0}, 1);
    pulse('{frame_done: 1'b1, frame_written: 1'b1, payload_len: 16'h0010, default: '0}, 1);
    pulse('{frame_done: 1'b1, frame_written: 1'b1, payload_len: 16'h0020, default: '0}, 1);
    pulse('{frame_done: 1'b1, frame_written: 1'b1, payload_len: 16'h0021, default: '0}, 2);
    wb(1'b1, 9'h1b4, 32'h0);
    wb(1'b1, 9'h1b8, 32'h0);
    rd_chk(9'h1b0, 32'h00000001);
    rd_chk(9'h1b8, 32'h00000002);
    $display("test limits done");
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_overrun();
    t_short();
    t_flags();
    t_long();
    t_limits();
    final_report();
  end
endmodule
